// ==== src/isr_core.sv ====
/*
 Status reporting core: summary status byte, latched event status
 register with its enable mask, service request enable, service request.
 Assumes the command parser on the same clock drives one-cycle strobes,
 and the lower operation/questionable registers supply event and enable
 vectors on the same clock.
*/
// How it works
// (R1) Status bit 4 follows the message available input.
// (R2) Status bit 5 is the OR of event bits ANDed with their enables.
// (R3) Status bit 6 is set when any other enabled status bit is set.
// (R4) Status bit 7 is the enabled summary of the operation events.
// (R5) Event register is a latch read by command; its mask is rw.
// (R6) Operation complete sets event bit 0 once all work is idle.
// (R7) Query errors set event bit 2.
// (R8) Device errors set event bit 3 and queue their error code.
// (R9) Execution errors set event bit 4 and queue their error code.
// (R10) Command errors set event bit 5 and queue their error code.
// (R11) Event bit 7 is set at power on.
// (R12) Status bit 2 shows a non-empty error queue.
// (R13) Status bit 3 is the enabled summary of questionable events.
// (R14) A rising enabled status bit raises service request; enable 6 ignored.
// (R15) Reading the event register clears it.
// (R16) Unused event bits 1, 6 and status bits 0, 1 read as zero.
// (R17) Event bits stay latched until the register is read.
`timescale 1ns/1ps
`default_nettype none
module isr_core
    import isr_pkg::*;
(
    // Clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       srst,
    // Command port
    input  wire logic                       cmd_valid,
    input  wire isr_pkg::isr_cmd_type       cmd_code,
    input  wire logic [isr_pkg::STAT_W-1:0] cmd_wdata,
    output logic                            rsp_valid,
    output logic [isr_pkg::STAT_W-1:0]      rsp_data,
    // Execution state
    input  wire logic                       exec_busy,
    input  wire logic                       msg_avail,
    // Error reports
    input  wire logic                       qry_err,
    input  wire logic                       dev_err,
    input  wire logic                       exe_err,
    input  wire logic                       cmd_err,
    input  wire logic [isr_pkg::ERR_W-1:0]  err_code,
    input  wire logic                       errq_empty,
    output logic                            errq_push,
    output logic [isr_pkg::ERR_W-1:0]       errq_code,
    // Lower register summaries
    input  wire logic [15:0]                oper_event,
    input  wire logic [15:0]                oper_enable,
    input  wire logic [15:0]                ques_event,
    input  wire logic [15:0]                ques_enable,
    // Outputs
    output logic [isr_pkg::STAT_W-1:0]      status_byte,
    output logic                            srq
);
    import isr_pkg::*;

    // ==========================================================
    // Storage
    logic [STAT_W-1:0] ev_r;
    logic [STAT_W-1:0] ena_r;
    logic [STAT_W-1:0] sre_r;
    logic [STAT_W-1:0] sb_prev_r;
    logic              opc_pend_r;
    logic              srq_r;
    logic [STAT_W-1:0] ev_set;
    logic [STAT_W-1:0] sb_raw;
    logic [STAT_W-1:0] sb_low;
    logic              esb_sum;
    logic              oper_sum;
    logic              ques_sum;
    logic              mss;
    logic              opc_done;
    logic              rd_ev;

    assign rd_ev = cmd_valid && (cmd_code == ISR_CMD_READ_EV);
    assign opc_done = opc_pend_r && !exec_busy;

    // ==========================================================
    // Enabled summaries
    isr_sum #(.W(STAT_W)) u_esb (
        .event_bits  (ev_r),
        .enable_bits (ena_r),
        .sum_bit     (esb_sum)
    ); // R2
    isr_sum #(.W(16)) u_oper (
        .event_bits  (oper_event),
        .enable_bits (oper_enable),
        .sum_bit     (oper_sum)
    ); // R4
    isr_sum #(.W(16)) u_ques (
        .event_bits  (ques_event),
        .enable_bits (ques_enable),
        .sum_bit     (ques_sum)
    ); // R13

    // ==========================================================
    // Summary status byte
    always_comb begin
        sb_low          = '0;
        sb_low[SB_ERRQ] = !errq_empty; // R12
        sb_low[SB_QUES] = ques_sum; // R13
        sb_low[SB_MAV]  = msg_avail; // R1
        sb_low[SB_ESB]  = esb_sum; // R2
        sb_low[SB_OPER] = oper_sum; // R4
        sb_low          = sb_low & SB_USED_MASK; // R16
    end

    isr_sum #(.W(STAT_W)) u_mss (
        .event_bits  (sb_low),
        .enable_bits (sre_r & SRE_USE_MASK),
        .sum_bit     (mss)
    ); // R3

    always_comb begin
        sb_raw         = sb_low;
        sb_raw[SB_MSS] = mss; // R3
    end

    assign status_byte = sb_raw;

    // ==========================================================
    // Event set sources
    always_comb begin
        ev_set          = '0;
        ev_set[EV_OPC]  = opc_done; // R6
        ev_set[EV_QYE]  = qry_err; // R7
        ev_set[EV_DDE]  = dev_err; // R8
        ev_set[EV_EXE]  = exe_err; // R9
        ev_set[EV_CME]  = cmd_err; // R10
        ev_set          = ev_set & EV_USED_MASK; // R16
    end

    // ==========================================================
    // Latched event register, cleared by read, set wins
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ev_r <= EV_RST; // R11
        end else if (rd_ev) begin
            ev_r <= ev_set; // R15
        end else begin
            ev_r <= ev_r | ev_set; // R17
        end
    end

    // ==========================================================
    // Operation complete tracking
    always_ff @(posedge core_clk) begin
        if (srst) begin
            opc_pend_r <= 1'b0;
        end else if (cmd_valid && cmd_code == ISR_CMD_OPC) begin
            opc_pend_r <= 1'b1; // R6
        end else if (opc_done) begin
            opc_pend_r <= 1'b0;
        end
    end

    // ==========================================================
    // Enable masks
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ena_r <= ENA_RST;
        end else if (cmd_valid && cmd_code == ISR_CMD_WR_ENA) begin
            ena_r <= cmd_wdata; // R5
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sre_r <= SRE_RST;
        end else if (cmd_valid && cmd_code == ISR_CMD_WR_SRE) begin
            sre_r <= cmd_wdata & SRE_USE_MASK; // R14
        end
    end

    // ==========================================================
    // Read responses
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rsp_valid <= 1'b0;
            rsp_data  <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (cmd_valid) begin
                case (cmd_code)
                    ISR_CMD_READ_EV: begin
                        rsp_valid <= 1'b1;
                        rsp_data  <= ev_r & EV_USED_MASK; // R5
                    end
                    ISR_CMD_RD_ENA: begin
                        rsp_valid <= 1'b1;
                        rsp_data  <= ena_r; // R5
                    end
                    ISR_CMD_RD_SRE: begin
                        rsp_valid <= 1'b1;
                        rsp_data  <= sre_r;
                    end
                    ISR_CMD_RD_STAT: begin
                        rsp_valid <= 1'b1;
                        rsp_data  <= sb_raw;
                    end
                    default: begin
                        rsp_valid <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Error queue push
    always_ff @(posedge core_clk) begin
        if (srst) begin
            errq_push <= 1'b0;
            errq_code <= '0;
        end else begin
            errq_push <= dev_err || exe_err || cmd_err; // R8 R9 R10
            errq_code <= err_code;
        end
    end

    // ==========================================================
    // Service request on rising enabled status bit
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sb_prev_r <= '0;
            srq_r     <= 1'b0;
        end else begin
            sb_prev_r <= sb_low;
            if (|(sb_low & ~sb_prev_r & sre_r & SRE_USE_MASK)) begin
                srq_r <= 1'b1; // R14
            end else if (!mss) begin
                srq_r <= 1'b0; // R3
            end
        end
    end

    assign srq = srq_r;
endmodule
`default_nettype wire

// ==== src/isr_pkg.sv ====
/*
 Shared constants for the status reporting core: bit positions of the
 summary status byte and the latched event status register, reset values,
 command codes of the command port and error code layout.
 Assumes a single core clock domain; no timing counts are needed.
*/
package isr_pkg;
    // ==========================================================
    // Widths
    localparam int STAT_W = 8;
    localparam int ERR_W  = 16;
    localparam int CMD_W  = 3;

    // ==========================================================
    // Summary status byte bit positions
    localparam int SB_ERRQ = 2;
    localparam int SB_QUES = 3;
    localparam int SB_MAV  = 4;
    localparam int SB_ESB  = 5;
    localparam int SB_MSS  = 6;
    localparam int SB_OPER = 7;

    // ==========================================================
    // Latched event status bit positions
    localparam int EV_OPC  = 0;
    localparam int EV_QYE  = 2;
    localparam int EV_DDE  = 3;
    localparam int EV_EXE  = 4;
    localparam int EV_CME  = 5;
    localparam int EV_PON  = 7;

    // Bits that may ever read as one
    localparam logic [STAT_W-1:0] EV_USED_MASK = 8'hBD;
    localparam logic [STAT_W-1:0] SB_USED_MASK = 8'hFC;
    localparam logic [STAT_W-1:0] SRE_USE_MASK = 8'hBF;

    // ==========================================================
    // Reset values
    localparam logic [STAT_W-1:0] EV_RST  = 8'h80;
    localparam logic [STAT_W-1:0] ENA_RST = 8'h00;
    localparam logic [STAT_W-1:0] SRE_RST = 8'h00;

    // ==========================================================
    // Commands on the command port
    typedef enum logic [CMD_W-1:0] {
        ISR_CMD_NOP      = 3'h0,
        ISR_CMD_READ_EV  = 3'h1,
        ISR_CMD_WR_ENA   = 3'h2,
        ISR_CMD_RD_ENA   = 3'h3,
        ISR_CMD_WR_SRE   = 3'h4,
        ISR_CMD_RD_SRE   = 3'h5,
        ISR_CMD_RD_STAT  = 3'h6,
        ISR_CMD_OPC      = 3'h7
    } isr_cmd_type;

    // Error code origins
    typedef enum logic [1:0] {
        ISR_SRC_DEV  = 2'h0,
        ISR_SRC_EXEC = 2'h1,
        ISR_SRC_CMD  = 2'h2,
        ISR_SRC_QRY  = 2'h3
    } isr_src_type;
endpackage

// ==== src/isr_sum.sv ====
/*
 Enabled summary: OR over event bits each ANDed with an enable bit.
 Assumes purely combinational use inside the status core.
*/
`timescale 1ns/1ps
`default_nettype none
module isr_sum #(
    parameter int W = 8
) (
    // Operands
    input  wire logic [W-1:0] event_bits,
    input  wire logic [W-1:0] enable_bits,
    // Result
    output logic              sum_bit
);
    assign sum_bit = |(event_bits & enable_bits);
endmodule
`default_nettype wire

// ==== bench/isr_checker.sv ====
/* Port checker for isr_core.
   Bound to isr_core; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module isr_checker
    import isr_pkg::*;
(
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              srst,
    // Command side
    input wire logic              cmd_valid,
    input wire isr_cmd_type       cmd_code,
    input wire logic              rsp_valid,
    // Errors
    input wire logic              dev_err,
    input wire logic              exe_err,
    input wire logic              cmd_err,
    input wire logic [ERR_W-1:0]  err_code,
    input wire logic              errq_push,
    input wire logic [ERR_W-1:0]  errq_code,
    // Status
    input wire logic              msg_avail,
    input wire logic              errq_empty,
    input wire logic [15:0]       oper_event,
    input wire logic [15:0]       oper_enable,
    input wire logic [15:0]       ques_event,
    input wire logic [15:0]       ques_enable,
    input wire logic [STAT_W-1:0] status_byte,
    input wire logic              srq
);
    wire rd_req = cmd_valid && (cmd_code inside {ISR_CMD_READ_EV,
        ISR_CMD_RD_ENA, ISR_CMD_RD_SRE, ISR_CMD_RD_STAT});
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // ==========================================================
    // Status byte
    property p_mav; status_byte[SB_MAV] == msg_avail; endproperty
    a_mav: assert property (p_mav) else $error("mav bit wrong");
    property p_errq; status_byte[SB_ERRQ] == !errq_empty; endproperty
    a_errq: assert property (p_errq) else $error("errq bit wrong");
    property p_ques;
        status_byte[SB_QUES] == |(ques_event & ques_enable);
    endproperty
    a_ques: assert property (p_ques) else $error("ques bit wrong");
    property p_oper;
        status_byte[SB_OPER] == |(oper_event & oper_enable);
    endproperty
    a_oper: assert property (p_oper) else $error("oper bit wrong");
    property p_unused; status_byte[1:0] == 2'h0; endproperty
    a_unused: assert property (p_unused) else $error("low bits set");
    property p_mss_zero;
        (status_byte & 8'hBF) == 8'h00 |-> !status_byte[SB_MSS];
    endproperty
    a_mss_zero: assert property (p_mss_zero) else $error("mss alone");
    // ==========================================================
    // Service request
    sequence s_mss_off; !status_byte[SB_MSS]; endsequence
    sequence s_mss_up; status_byte[SB_MSS] && !$past(cmd_valid); endsequence
    property p_srq_up; s_mss_off ##1 s_mss_up |=> srq; endproperty
    a_srq_up: assert property (p_srq_up) else $error("srq missing");
    property p_srq_off; s_mss_off |=> !srq; endproperty
    a_srq_off: assert property (p_srq_off) else $error("srq stuck");
    // ==========================================================
    // Responses and error queue
    property p_rsp; 1'b1 |=> rsp_valid == $past(rd_req); endproperty
    a_rsp: assert property (p_rsp) else $error("rsp timing wrong");
    property p_push;
        (dev_err || exe_err || cmd_err)
            |=> errq_push && errq_code == $past(err_code);
    endproperty
    a_push: assert property (p_push) else $error("push wrong");
endmodule
bind isr_core isr_checker u_isr_checker (.core_clk, .srst, .cmd_valid,
    .cmd_code, .rsp_valid, .dev_err, .exe_err, .cmd_err, .err_code,
    .errq_push, .errq_code, .msg_avail, .errq_empty, .oper_event,
    .oper_enable, .ques_event, .ques_enable, .status_byte, .srq);
`default_nettype wire

// ==== bench/isr_host.sv ====
/* Remote controller model issuing commands.
   Assumes the core takes commands at the rising edge. */
`timescale 1ns/1ps
`default_nettype none
module isr_host
    import isr_pkg::*;
(
    // Clock
    input  wire logic              core_clk,
    // Command side
    output var  logic              cmd_valid,
    output var  isr_cmd_type       cmd_code,
    output var  logic [STAT_W-1:0] cmd_wdata,
    // Response side
    input  wire logic              rsp_valid,
    input  wire logic [STAT_W-1:0] rsp_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = ISR_CMD_NOP;
        cmd_wdata = 8'h00;
    end
    // One command; data not kept after the taking edge
    task automatic xfer(input isr_cmd_type c, input logic [7:0] d,
                        output logic [7:0] r, output logic v);
        @(negedge core_clk);
        cmd_valid = 1'b1;
        cmd_code  = c;
        cmd_wdata = d;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        cmd_code  = ISR_CMD_NOP;
        cmd_wdata = ~d;
        v = rsp_valid;
        r = rsp_valid ? rsp_data : 8'hXX;
    endtask
endmodule
`default_nettype wire

// ==== bench/ieee4882_status_reporting_tb.sv ====
/* Self-checking bench for isr_core.
   Assumes isr_host drives commands, bench drives the rest. */
`timescale 1ns/1ps
`default_nettype none
module ieee4882_status_reporting_tb;
    import isr_pkg::*;
    logic core_clk, srst, cmd_valid, rsp_valid, srq, errq_push;
    logic exec_busy, msg_avail, errq_empty, qry_err, dev_err, exe_err;
    logic cmd_err;
    isr_cmd_type cmd_code;
    logic [7:0]  cmd_wdata, rsp_data, status_byte;
    logic [15:0] err_code, errq_code, oper_event, oper_enable;
    logic [15:0] ques_event, ques_enable;
    int          fail_count, cmp_count;
    isr_core u_isr_core (.core_clk, .srst, .cmd_valid, .cmd_code,
        .cmd_wdata, .rsp_valid, .rsp_data, .exec_busy, .msg_avail,
        .qry_err, .dev_err, .exe_err, .cmd_err, .err_code, .errq_empty,
        .errq_push, .errq_code, .oper_event, .oper_enable, .ques_event,
        .ques_enable, .status_byte, .srq);
    isr_host u_isr_host (.core_clk, .cmd_valid, .cmd_code, .cmd_wdata,
        .rsp_valid, .rsp_data);
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // ==========================================================
    // Helpers
    task automatic chk(input string nm, input logic [15:0] s, e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rdx(input isr_cmd_type c, input logic [7:0] e);
        logic [7:0] r;
        logic       v;
        u_isr_host.xfer(c, 8'h00, r, v);
        chk("rspv", {15'h0, v}, 16'h0001);
        chk(c.name(), {8'h00, r}, {8'h00, e});
    endtask
    task automatic wr(input isr_cmd_type c, input logic [7:0] d);
        logic [7:0] r;
        logic       v;
        u_isr_host.xfer(c, d, r, v);
        chk("norsp", {15'h0, v}, 16'h0000);
    endtask
    task automatic pulse(input logic [3:0] v, input logic [15:0] code);
        @(negedge core_clk);
        {qry_err, dev_err, exe_err, cmd_err} = v;
        err_code = code;
        @(negedge core_clk);
        {qry_err, dev_err, exe_err, cmd_err} = 4'h0;
        err_code = ~code;
        chk("push", {15'h0, errq_push}, {15'h0, |v[2:0]});
        if (|v[2:0]) chk("code", errq_code, code);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_power();
        rdx(ISR_CMD_READ_EV, 8'h80);
        rdx(ISR_CMD_READ_EV, 8'h00);
        rdx(ISR_CMD_RD_ENA, 8'h00);
        wr(ISR_CMD_NOP, 8'h00);
        chk("status", {8'h00, status_byte}, 16'h0000);
        $display("power test done");
    endtask
    task automatic t_errors();
        logic [7:0] r;
        logic       v;
        pulse(4'h8, 16'h0000);
        pulse(4'h4, 16'hFEA2);
        pulse(4'h2, 16'hFF06);
        pulse(4'h1, 16'hFF6A);
        repeat (3) @(negedge core_clk);
        rdx(ISR_CMD_READ_EV, 8'h3C);
        rdx(ISR_CMD_READ_EV, 8'h00);
        fork
            u_isr_host.xfer(ISR_CMD_READ_EV, 8'h00, r, v);
            pulse(4'h4, 16'hFEA2);
        join
        chk("clash", {7'h00, v, r}, 16'h0100);
        rdx(ISR_CMD_READ_EV, 8'h08);
        $display("error test done");
    endtask
    task automatic t_enable();
        wr(ISR_CMD_WR_ENA, 8'h3C);
        rdx(ISR_CMD_RD_ENA, 8'h3C);
        wr(ISR_CMD_WR_SRE, 8'hFF);
        rdx(ISR_CMD_RD_SRE, 8'hBF);
        wr(ISR_CMD_WR_SRE, 8'h20);
        pulse(4'h2, 16'hFF06);
        @(negedge core_clk);
        chk("status", {8'h00, status_byte}, 16'h0060);
        chk("srq", {15'h0, srq}, 16'h0001);
        rdx(ISR_CMD_READ_EV, 8'h10);
        @(negedge core_clk);
        chk("srq", {15'h0, srq}, 16'h0000);
        $display("enable test done");
    endtask
    task automatic t_opc();
        exec_busy = 1'b1;
        wr(ISR_CMD_OPC, 8'h00);
        repeat (3) @(negedge core_clk);
        rdx(ISR_CMD_READ_EV, 8'h00);
        exec_busy = 1'b0;
        @(negedge core_clk);
        rdx(ISR_CMD_READ_EV, 8'h01);
        $display("opc test done");
    endtask
    task automatic t_summary();
        msg_avail = 1'b1;
        errq_empty = 1'b0;
        ques_event = 16'h0010;
        ques_enable = 16'h0010;
        oper_event = 16'h0001;
        oper_enable = 16'h0002;
        @(negedge core_clk);
        chk("status", {8'h00, status_byte}, 16'h001C);
        oper_enable = 16'h0001;
        rdx(ISR_CMD_RD_STAT, 8'h9C);
        wr(ISR_CMD_WR_SRE, 8'h10);
        @(negedge core_clk);
        chk("srq", {15'h0, srq}, 16'h0000);
        msg_avail = 1'b0;
        @(negedge core_clk);
        msg_avail = 1'b1;
        repeat (2) @(negedge core_clk);
        chk("status", {8'h00, status_byte}, 16'h00DC);
        chk("srq", {15'h0, srq}, 16'h0001);
        $display("summary test done");
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        tally_and_finish();
    end
    initial begin
        {srst, exec_busy, msg_avail, errq_empty} = 4'b1001;
        {qry_err, dev_err, exe_err, cmd_err} = 4'h0;
        {err_code, oper_event, oper_enable} = 48'h0;
        {ques_event, ques_enable} = 32'h0;
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
        t_power();
        t_errors();
        t_enable();
        t_opc();
        t_summary();
        tally_and_finish();
    end
endmodule
`default_nettype wire
